// File: rtl/ffs_defines.vh
`ifndef FFS_DEFINES_VH
`define FFS_DEFINES_VH

// =====================================================
// Command codes
`define FFS_CMD_FAN1_LIMIT     8'h02
`define FFS_CMD_FAN2_LIMIT     8'h03
`define FFS_CMD_CONTROL        8'h04
`define FFS_CMD_FLAGS          8'h05

// =====================================================
// Reset values
`define FFS_LIMIT_RESET        8'h0a
`define FFS_CONTROL_RESET      8'h0a

// =====================================================
// Control field positions
`define FFS_CTL_STALL_CLEAR    7
`define FFS_CTL_STEP_SELECT    6
`define FFS_CTL_PWM_SOURCE     5
`define FFS_CTL_FAN2_PPT_HI    4
`define FFS_CTL_FAN2_PPT_LO    3
`define FFS_CTL_FAN1_PPT_HI    2
`define FFS_CTL_FAN1_PPT_LO    1
`define FFS_CTL_POWER_DOWN     0

// =====================================================
// Status field positions
`define FFS_ST_OVERHEAT        5
`define FFS_ST_TACH2_OVF       4
`define FFS_ST_TACH1_OVF       3
`define FFS_ST_TEMP_OPEN       2
`define FFS_ST_FAN2_STALL      1
`define FFS_ST_FAN1_STALL      0

// =====================================================
// Timing
`define FFS_CLK_KHZ            200000
`define FFS_STALL_TIME_MS      2400
// 2.4 s at 200 MHz, sized to the stall timer width
`define FFS_STALL_CYCLES       29'd480000000
`define FFS_STRAP_DELAY        2'h3

`endif

// File: rtl/ffs_regs.v
`timescale 1ns/100ps
`include "ffs_defines.vh"

module ffs_regs #(
	parameter        CNT_W        = 29,
	parameter [28:0] STALL_CYCLES = `FFS_STALL_CYCLES
) (
	input  wire       MCLK_I,
	input  wire       RST_N_I,
	input  wire [7:0] CMD_I,
	input  wire       WR_I,
	input  wire [7:0] WDATA_I,
	input  wire       RD_I,
	input  wire [8:0] FAN1_SPEED_COUNT_I,
	input  wire [8:0] FAN2_SPEED_COUNT_I,
	input  wire       TACH1_OVERFLOW_I,
	input  wire       TACH2_OVERFLOW_I,
	input  wire       TEMP_OPEN_PIN_I,
	input  wire       OVERHEAT_PIN_I,
	output reg  [7:0] RDATA_O,
	output reg        RVALID_O,
	output reg        FAULT_N_O,
	output reg        SPEED_STEP_SELECT_O,
	output reg        PWM_SOURCE_SELECT_O,
	output reg        FIXED_DUTY_O,
	output reg  [1:0] FAN1_PULSES_PER_TURN_O,
	output reg  [1:0] FAN2_PULSES_PER_TURN_O,
	output reg        POWER_DOWN_SELECT_O
);

	// =====================================================
	// Speed against limit
	// Limit is in 50 RPM steps; in fine mode one result step is 25 RPM,
	// so the limit is doubled before the compare.
	function below_limit;
		input [8:0] speed;
		input [7:0] limit;
		input       fine;
		begin
			if (fine) begin
				below_limit = speed < {limit, 1'b0};
			end else begin
				below_limit = speed < {1'b0, limit};
			end
		end
	endfunction

	// =====================================================
	// Registers and state
	reg [7:0]       fan1_stall_limit;
	reg [7:0]       fan2_stall_limit;
	reg [7:0]       control_settings;
	reg             fan1_stall_flag;
	reg             fan2_stall_flag;
	reg [CNT_W-1:0] fan1_low_count;
	reg [CNT_W-1:0] fan2_low_count;
	reg             temp_open_meta;
	reg             temp_open_sync;
	reg             overheat_meta;
	reg             overheat_sync;
	reg             temp_input_open;
	reg             overheat_flag;
	reg [1:0]       strap_delay;
	reg             strap_done;

	wire        stall_clear      = control_settings[`FFS_CTL_STALL_CLEAR];
	wire        fine_step        = control_settings[`FFS_CTL_STEP_SELECT];
	wire        fan1_low         = below_limit(FAN1_SPEED_COUNT_I,
	                                           fan1_stall_limit, fine_step);
	wire        fan2_low         = below_limit(FAN2_SPEED_COUNT_I,
	                                           fan2_stall_limit, fine_step);
	wire        fan1_expired     = (fan1_low_count == STALL_CYCLES);
	wire        fan2_expired     = (fan2_low_count == STALL_CYCLES);
	wire        next_fan1_stall;
	wire        next_fan2_stall;
	reg  [7:0]  condition_flags;
	reg  [7:0]  read_mux;

	// =====================================================
	// Register writes by command code
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			fan1_stall_limit <= `FFS_LIMIT_RESET;
			fan2_stall_limit <= `FFS_LIMIT_RESET;
			control_settings <= `FFS_CONTROL_RESET;
		end else if (WR_I) begin
			case (CMD_I)
				`FFS_CMD_FAN1_LIMIT: fan1_stall_limit <= WDATA_I;
				`FFS_CMD_FAN2_LIMIT: fan2_stall_limit <= WDATA_I;
				`FFS_CMD_CONTROL:    control_settings <= WDATA_I;
				default: begin
				end
			endcase
		end
	end

	// =====================================================
	// Two-flop synchronisers for the analog comparator levels
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			temp_open_meta <= 1'b0;
			temp_open_sync <= 1'b0;
			overheat_meta  <= 1'b0;
			overheat_sync  <= 1'b0;
		end else begin
			temp_open_meta <= TEMP_OPEN_PIN_I;
			temp_open_sync <= temp_open_meta;
			overheat_meta  <= OVERHEAT_PIN_I;
			overheat_sync  <= overheat_meta;
		end
	end

	// =====================================================
	// Catch the input checks once after reset release
	// Waits until the synchronisers hold a real sample.
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			strap_delay     <= 2'h0;
			strap_done      <= 1'b0;
			temp_input_open <= 1'b0;
			overheat_flag   <= 1'b0;
		end else if (!strap_done) begin
			if (strap_delay == `FFS_STRAP_DELAY) begin
				strap_done      <= 1'b1;
				temp_input_open <= temp_open_sync;
				overheat_flag   <= overheat_sync;
			end else begin
				strap_delay <= strap_delay + 2'h1;
			end
		end
	end

	// =====================================================
	// Low-speed timers, saturating at the stall time
	// Any cycle back at or above the limit restarts the wait.
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			fan1_low_count <= {CNT_W{1'b0}};
			fan2_low_count <= {CNT_W{1'b0}};
		end else begin
			if (!fan1_low) begin
				fan1_low_count <= {CNT_W{1'b0}};
			end else if (!fan1_expired) begin
				fan1_low_count <= fan1_low_count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			if (!fan2_low) begin
				fan2_low_count <= {CNT_W{1'b0}};
			end else if (!fan2_expired) begin
				fan2_low_count <= fan2_low_count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// =====================================================
	// Sticky stall flags
	// The clear bit is a level: while it is 1 the flags are held clear,
	// so software must write it back to 0 before new stalls can show.
	assign next_fan1_stall = stall_clear ? 1'b0 :
	                         (fan1_stall_flag | fan1_expired);
	assign next_fan2_stall = stall_clear ? 1'b0 :
	                         (fan2_stall_flag | fan2_expired);

	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			fan1_stall_flag <= 1'b0;
			fan2_stall_flag <= 1'b0;
			FAULT_N_O       <= 1'b1;
		end else begin
			fan1_stall_flag <= next_fan1_stall;
			fan2_stall_flag <= next_fan2_stall;
			FAULT_N_O       <= ~(next_fan1_stall | next_fan2_stall);
		end
	end

	// =====================================================
	// Status image
	always @* begin
		condition_flags                     = 8'h00;
		condition_flags[`FFS_ST_OVERHEAT]   = overheat_flag;
		condition_flags[`FFS_ST_TACH2_OVF]  = TACH2_OVERFLOW_I;
		condition_flags[`FFS_ST_TACH1_OVF]  = TACH1_OVERFLOW_I;
		condition_flags[`FFS_ST_TEMP_OPEN]  = temp_input_open;
		condition_flags[`FFS_ST_FAN2_STALL] = fan2_stall_flag;
		condition_flags[`FFS_ST_FAN1_STALL] = fan1_stall_flag;
	end

	// =====================================================
	// Read decode; unknown codes read as zero
	always @* begin
		case (CMD_I)
			`FFS_CMD_FAN1_LIMIT: read_mux = fan1_stall_limit;
			`FFS_CMD_FAN2_LIMIT: read_mux = fan2_stall_limit;
			`FFS_CMD_CONTROL:    read_mux = control_settings;
			`FFS_CMD_FLAGS:      read_mux = condition_flags;
			default:             read_mux = 8'h00;
		endcase
	end

	// =====================================================
	// Read answer, one cycle after the request
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			RDATA_O  <= 8'h00;
			RVALID_O <= 1'b0;
		end else begin
			RVALID_O <= RD_I;
			if (RD_I) begin
				RDATA_O <= read_mux;
			end
		end
	end

	// =====================================================
	// Control outputs to the fan logic
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			SPEED_STEP_SELECT_O    <= 1'b0;
			PWM_SOURCE_SELECT_O    <= 1'b0;
			FIXED_DUTY_O           <= 1'b0;
			FAN1_PULSES_PER_TURN_O <= 2'h1;
			FAN2_PULSES_PER_TURN_O <= 2'h1;
			POWER_DOWN_SELECT_O    <= 1'b0;
		end else begin
			SPEED_STEP_SELECT_O    <= fine_step;
			PWM_SOURCE_SELECT_O    <= control_settings[`FFS_CTL_PWM_SOURCE];
			FIXED_DUTY_O           <= ~control_settings[`FFS_CTL_PWM_SOURCE]
			                          & temp_input_open;
			FAN1_PULSES_PER_TURN_O <= control_settings[`FFS_CTL_FAN1_PPT_HI:
			                                           `FFS_CTL_FAN1_PPT_LO];
			FAN2_PULSES_PER_TURN_O <= control_settings[`FFS_CTL_FAN2_PPT_HI:
			                                           `FFS_CTL_FAN2_PPT_LO];
			POWER_DOWN_SELECT_O    <= control_settings[`FFS_CTL_POWER_DOWN];
		end
	end

endmodule // ffs_regs

// File: tb/ffs_regs_asserts.sv
`timescale 1ns/100ps
module ffs_regs_asserts (
	input wire       MCLK_I,
	input wire       RST_N_I,
	input wire [7:0] CMD_I,
	input wire       WR_I,
	input wire [7:0] WDATA_I,
	input wire       RD_I,
	input wire [7:0] RDATA_O,
	input wire       RVALID_O,
	input wire       FAULT_N_O,
	input wire       SPEED_STEP_SELECT_O,
	input wire       PWM_SOURCE_SELECT_O,
	input wire [1:0] FAN1_PULSES_PER_TURN_O,
	input wire [1:0] FAN2_PULSES_PER_TURN_O,
	input wire       POWER_DOWN_SELECT_O
);
	// ====
	// Port checks
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	wire ctl_wr = WR_I && (CMD_I == 8'h04);

	rd_answer_a: assert property (RD_I |=> RVALID_O) else $error("read unanswered");
	rd_cause_a: assert property (RVALID_O |-> $past(RD_I)) else $error("stray answer");
	bad_cmd_a: assert property (
		RD_I && (CMD_I < 8'h02 || CMD_I > 8'h05) |=> RDATA_O == 8'h00) else $error("bad read");
	ctl_out_a: assert property (
		ctl_wr ##1 !ctl_wr |=> {SPEED_STEP_SELECT_O, PWM_SOURCE_SELECT_O,
		FAN2_PULSES_PER_TURN_O, FAN1_PULSES_PER_TURN_O, POWER_DOWN_SELECT_O}
		== $past(WDATA_I[6:0], 2)) else $error("control outputs wrong");
	stat_ro_a: assert property (
		RD_I && CMD_I == 8'h05 |=> RDATA_O[7:6] == 2'h0) else $error("status top bits");
	clear_wins_a: assert property (
		ctl_wr && WDATA_I[7] |=> ##1 FAULT_N_O) else $error("alert not released");
	fault_hold_a: assert property (
		!FAULT_N_O && !ctl_wr && !$past(ctl_wr && WDATA_I[7]) |=> !FAULT_N_O)
		else $error("alert dropped");
	fault_rel_a: assert property (
		$rose(FAULT_N_O) |-> $past(ctl_wr && WDATA_I[7], 2)) else $error("alert freed early");
endmodule // ffs_regs_asserts

bind ffs_regs ffs_regs_asserts CHK (.MCLK_I, .RST_N_I, .CMD_I, .WR_I, .WDATA_I, .RD_I,
	.RDATA_O, .RVALID_O, .FAULT_N_O, .SPEED_STEP_SELECT_O, .PWM_SOURCE_SELECT_O,
	.FAN1_PULSES_PER_TURN_O, .FAN2_PULSES_PER_TURN_O, .POWER_DOWN_SELECT_O);

// File: tb/ffs_host.sv
`timescale 1ns/100ps
module ffs_host (
	input  wire       MCLK_I,
	input  wire [7:0] RDATA_O,
	input  wire       RVALID_O,
	output reg  [7:0] CMD_O,
	output reg        WR_O,
	output reg  [7:0] WDATA_O,
	output reg        RD_O
);
	// ====
	// Idle host
	initial begin
		CMD_O = 8'h00;
		WR_O = 1'b0;
		WDATA_O = 8'h00;
		RD_O = 1'b0;
	end
	// Write byte, one strobe per command
	task wr(input [7:0] c, input [7:0] d);
		begin
			@(negedge MCLK_I);
			CMD_O = c;
			WDATA_O = d;
			WR_O = 1'b1;
			@(negedge MCLK_I);
			WR_O = 1'b0;
			WDATA_O = ~d;
		end
	endtask
	// Read byte, wait a bounded time for the answer
	task rd(input [7:0] c, output [7:0] d);
		integer n;
		begin
			n = 0;
			@(negedge MCLK_I);
			CMD_O = c;
			RD_O = 1'b1;
			@(negedge MCLK_I);
			RD_O = 1'b0;
			while (RVALID_O !== 1'b1 && n < 3) begin
				n = n + 1;
				@(negedge MCLK_I);
			end
			d = RDATA_O;
		end
	endtask
endmodule // ffs_host

// File: tb/ffs_regs_tb_top.sv
`timescale 1ns/100ps
module ffs_regs_tb_top;
	// ====
	// Stimulus and DUT
	reg        mclk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [8:0] spd1 = 9'h1ff;
	reg  [8:0] spd2 = 9'h1ff;
	reg        ovf1 = 1'b0;
	reg        ovf2 = 1'b0;
	reg        ovh = 1'b0;
	reg        topen = 1'b1;
	wire [6:0] ctl;
	reg  [7:0] d;
	reg [23:0] rows [0:6];
	wire [7:0] cmd, wdata, rdata;
	wire       wr, rd, rvalid, fault_n, fixed;
	integer    error_cnt = 0;
	integer    tests_run = 0;
	integer    i;

	always #2.5 mclk = ~mclk;

	ffs_regs #(.STALL_CYCLES(29'd20)) DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .CMD_I(cmd),
		.WR_I(wr), .WDATA_I(wdata), .RD_I(rd), .FAN1_SPEED_COUNT_I(spd1),
		.FAN2_SPEED_COUNT_I(spd2), .TACH1_OVERFLOW_I(ovf1), .TACH2_OVERFLOW_I(ovf2),
		.TEMP_OPEN_PIN_I(topen), .OVERHEAT_PIN_I(ovh), .RDATA_O(rdata), .RVALID_O(rvalid),
		.FAULT_N_O(fault_n), .SPEED_STEP_SELECT_O(ctl[6]), .PWM_SOURCE_SELECT_O(ctl[5]),
		.FIXED_DUTY_O(fixed), .FAN1_PULSES_PER_TURN_O(ctl[2:1]),
		.FAN2_PULSES_PER_TURN_O(ctl[4:3]), .POWER_DOWN_SELECT_O(ctl[0]));
	ffs_host HOST (.MCLK_I(mclk), .RDATA_O(rdata), .RVALID_O(rvalid), .CMD_O(cmd),
		.WR_O(wr), .WDATA_O(wdata), .RD_O(rd));

	// ====
	// Checking helpers
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task rchk(input [7:0] c, input [7:0] exp);
		begin
			HOST.rd(c, d);
			chk(d, exp);
		end
	endtask
	task summarize;
		begin
			if (error_cnt == 0 && tests_run > 0) begin
				$display("*** PASS ***");
			end else begin
				$display("*** FAIL ***");
			end
			$finish;
		end
	endtask

	// ====
	// Main sequence: reset, table of writes and reads, stall cases
	initial begin
		rows[0] = 24'h02ffff;
		rows[1] = 24'h035555;
		rows[2] = 24'h042a2a;
		rows[3] = 24'h05ff04;
		rows[4] = 24'h075500;
		rows[5] = 24'h020a0a;
		rows[6] = 24'h040a0a;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		repeat (5) @(negedge mclk);
		chk({7'h0, fixed}, 8'h01);
		rchk(8'h02, 8'h0a);
		rchk(8'h03, 8'h0a);
		rchk(8'h04, 8'h0a);
		for (i = 0; i < 7; i = i + 1) begin
			HOST.wr(rows[i][23:16], rows[i][15:8]);
			rchk(rows[i][23:16], rows[i][7:0]);
		end
		// Control outputs and fixed duty for the other field codes
		HOST.wr(8'h04, 8'h35);
		rchk(8'h04, 8'h35);
		chk({1'b0, ctl}, 8'h35);
		chk({7'h0, fixed}, 8'h00);
		HOST.wr(8'h04, 8'h59);
		rchk(8'h04, 8'h59);
		chk({1'b0, ctl}, 8'h59);
		chk({7'h0, fixed}, 8'h01);
		HOST.wr(8'h04, 8'h0a);
		// Fan 1 one step under its limit
		@(negedge mclk);
		spd1 = 9'h009;
		for (i = 0; i < 40 && fault_n !== 1'b0; i = i + 1) begin
			@(posedge mclk);
			#1;
		end
		chk(i[7:0], 8'd21);
		@(negedge mclk);
		spd1 = 9'h1ff;
		rchk(8'h05, 8'h05);
		HOST.wr(8'h04, 8'h8a);
		rchk(8'h05, 8'h04);
		chk({7'h0, fault_n}, 8'h01);
		HOST.wr(8'h04, 8'h4a);
		// Fine steps: fan 2 under twice its limit, fan 1 and fan 2 overflowing
		@(negedge mclk);
		spd2 = 9'h0a9;
		ovf1 = 1'b1;
		ovf2 = 1'b1;
		repeat (25) @(negedge mclk);
		rchk(8'h05, 8'h1e);
		chk({7'h0, fault_n}, 8'h00);
		ovf1 = 1'b0;
		spd2 = 9'h1ff;
		rchk(8'h05, 8'h16);
		// Second reset with the analog input checks the other way round
		rst_n = 1'b0;
		ovf2 = 1'b0;
		ovh = 1'b1;
		topen = 1'b0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		repeat (5) @(negedge mclk);
		chk({7'h0, fault_n}, 8'h01);
		chk({7'h0, fixed}, 8'h00);
		rchk(8'h05, 8'h20);
		rchk(8'h02, 8'h0a);
		summarize;
	end

	// Watchdog against a hang
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		summarize;
	end
endmodule // ffs_regs_tb_top
